//--- rtl/adc_pkg.sv
package adc_pkg;

  // ************************************************************
  // Word format
  // ************************************************************
  localparam int DATA_W = 10;
  localparam int PIPE_LATENCY = 5;
  localparam logic [9:0] MID_CODE = 10'h200;
  localparam logic [9:0] MAX_CODE = 10'h3FF;
  localparam logic [9:0] MIN_CODE = 10'h000;
  localparam logic [9:0] PD_PATTERN = 10'h000;
  localparam int MSB_POS = 9;

  // ************************************************************
  // Full-scale span, as 1024 * 65536 / span_mv
  // ************************************************************
  localparam int SPAN_2V0_MV = 2000;
  localparam int SPAN_1V5_MV = 1500;
  localparam int SPAN_1V0_MV = 1000;
  localparam int SCALE_SHIFT = 16;
  localparam logic [16:0] K_2V0 = 17'(64'd67108864 / SPAN_2V0_MV);
  localparam logic [16:0] K_1V5 = 17'(64'd67108864 / SPAN_1V5_MV);
  localparam logic [16:0] K_1V0 = 17'(64'd67108864 / SPAN_1V0_MV);

  typedef enum logic [1:0] {
    RANGE_2V0,
    RANGE_1V5,
    RANGE_1V0
  } range_e;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int CONV_MIN_MHZ = 20;
  localparam int CONV_MAX_MHZ = 80;
  localparam int CONV_HALF_CYC = 4;
  localparam int STALL_MAX_NS = 50;
  localparam int STALL_CYC = (STALL_MAX_NS * CLK_MHZ) / 1000;
  localparam int FIFO_DEPTH = 8;

endpackage : adc_pkg

//--- rtl/adc_link_if.sv
`timescale 1ns/100ps
interface adc_link_if;
  logic conv_clk;
  logic power_down_request;
  logic output_format_select;
  logic range_o;
  logic range_oe;
  logic range_hi;
  logic range_lo;
  logic [adc_pkg::DATA_W-1:0] data;

  // Three-level range pin: driven high, driven low or left floating
  assign range_hi = range_oe & range_o;
  assign range_lo = range_oe & ~range_o;

  modport converter (
    input conv_clk,
    input power_down_request,
    input output_format_select,
    input range_hi,
    input range_lo,
    output data
  );

  modport capture (
    output conv_clk,
    output power_down_request,
    output output_format_select,
    output range_o,
    output range_oe,
    input data
  );
endinterface : adc_link_if

//--- rtl/converter_end.sv
// How it works
// RULE_01: conversion clock edges time samples and pipeline
// RULE_02: clock source keeps 20 to 80 MHz
// RULE_03: clock source never stalls below 20 MSPS; capture_end stops it while run is low
// RULE_04: clock source aims for 50% duty
// RULE_05: power-down request high stops conversion
// RULE_06: output word meaningless during power-down
// RULE_07: power-down wipes in-flight samples; capture discards
// RULE_08: power-down acts without conversion clock
// RULE_09: format select high gives two's complement
// RULE_10: result driven on ten parallel bits
// RULE_11: capture latches on conversion clock rising edge
// RULE_12: range select sets 2.0, 1.5, 1.0 V span
// RULE_13: new word each cycle, fixed pipeline lag
// RULE_14: offset binary midscale between 1FF and 200
// RULE_15: two's complement is offset binary, MSB inverted
`timescale 1ns/100ps
module converter_end #(
  parameter int LATENCY = adc_pkg::PIPE_LATENCY
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link to capture logic
  adc_link_if.converter lk,
  // Analog input, differential millivolts
  input wire logic signed [15:0] ain_mv,
  // Status
  output logic powered_down_q,
  output logic sample_strobe_q,
  output logic decayed_q
);

  localparam int W = adc_pkg::DATA_W;
  localparam int NSYNC = 5;
  localparam logic [7:0] STALL_LIMIT = 8'(adc_pkg::STALL_CYC);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (LATENCY < 1 || LATENCY > 16) begin : bad_latency
    $error("converter_end: LATENCY must be 1 to 16");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic conv_prev_q;

  assign pins_raw = {lk.conv_clk, lk.power_down_request,
                     lk.output_format_select, lk.range_hi, lk.range_lo};

  // Two flops for every pin arriving from the far side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      conv_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      conv_prev_q <= sync2_q[4];
    end
  end

  // ************************************************************
  // Decoded controls
  // ************************************************************
  wire conv_s = sync2_q[4];
  wire pd_s = sync2_q[3];
  wire fmt_s = sync2_q[2];
  wire rng_hi_s = sync2_q[1];
  wire rng_lo_s = sync2_q[0];
  wire conv_edge = conv_s & ~conv_prev_q; // RULE_01

  // Span select from the three-level pin
  wire [16:0] scale_k = rng_hi_s ? adc_pkg::K_2V0 : // RULE_12
                        rng_lo_s ? adc_pkg::K_1V5 :
                        adc_pkg::K_1V0;

  // ************************************************************
  // Quantiser
  // ************************************************************
  logic signed [33:0] prod;
  logic signed [33:0] steps;
  logic signed [33:0] code_wide;
  logic [W-1:0] code_ob;
  localparam logic signed [33:0] MID_W = 34'(adc_pkg::MID_CODE);
  localparam logic signed [33:0] MAX_W = 34'(adc_pkg::MAX_CODE);

  // Scale, offset to midscale and clamp to the code range
  always_comb begin
    prod = 34'(ain_mv) * $signed({17'h00000, scale_k});
    steps = prod >>> adc_pkg::SCALE_SHIFT;
    code_wide = steps + MID_W; // RULE_14
    if (code_wide < 0) begin
      code_ob = adc_pkg::MIN_CODE;
    end else if (code_wide > MAX_W) begin
      code_ob = adc_pkg::MAX_CODE;
    end else begin
      code_ob = code_wide[W-1:0];
    end
  end

  // ************************************************************
  // Clock stall watch
  // ************************************************************
  logic [7:0] stall_cnt_q;
  logic [7:0] stall_cnt_d;
  wire stalled = (stall_cnt_q >= STALL_LIMIT);

  // Counts clocks since the last conversion edge, saturating
  assign stall_cnt_d = conv_edge ? 8'h00 :
                       stalled ? stall_cnt_q : stall_cnt_q + 8'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_q <= 8'h00;
    end else begin
      stall_cnt_q <= stall_cnt_d;
    end
  end

  // ************************************************************
  // Conversion pipeline
  // ************************************************************
  logic [W-1:0] stage_q [LATENCY];
  logic [LATENCY-1:0] vld_q;

  // Stage 0 takes a sample on each conversion edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q[0] <= adc_pkg::PD_PATTERN;
      vld_q[0] <= 1'b0;
    end else if (pd_s) begin
      stage_q[0] <= adc_pkg::PD_PATTERN; // RULE_07
      vld_q[0] <= 1'b0; // RULE_08
    end else if (conv_edge) begin
      stage_q[0] <= code_ob; // RULE_01
      vld_q[0] <= 1'b1;
    end else if (stalled) begin
      vld_q[0] <= 1'b0; // RULE_03
    end
  end

  // Later stages step forward one place per conversion edge
  for (genvar i = 1; i < LATENCY; i++) begin : g_stage
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stage_q[i] <= adc_pkg::PD_PATTERN;
        vld_q[i] <= 1'b0;
      end else if (pd_s) begin
        stage_q[i] <= adc_pkg::PD_PATTERN; // RULE_07
        vld_q[i] <= 1'b0;
      end else if (conv_edge) begin
        stage_q[i] <= stage_q[i-1]; // RULE_13
        vld_q[i] <= vld_q[i-1];
      end else if (stalled) begin
        vld_q[i] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Output stage
  // ************************************************************
  wire [W-1:0] last_ob = stage_q[LATENCY-1];
  wire [W-1:0] last_tc = {~last_ob[adc_pkg::MSB_POS],
                          last_ob[adc_pkg::MSB_POS-1:0]}; // RULE_15
  wire [W-1:0] out_word = fmt_s ? last_tc : last_ob; // RULE_09
  logic [W-1:0] data_q;

  // Word updates once per conversion edge, parked in power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= adc_pkg::PD_PATTERN;
    end else if (pd_s) begin
      data_q <= adc_pkg::PD_PATTERN; // RULE_06
    end else if (conv_edge) begin
      data_q <= out_word; // RULE_13
    end
  end

  assign lk.data = data_q; // RULE_10

  // ************************************************************
  // Status
  // ************************************************************
  // Power-down state follows the pin with no conversion clock needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powered_down_q <= 1'b0;
      sample_strobe_q <= 1'b0;
      decayed_q <= 1'b0;
    end else begin
      powered_down_q <= pd_s; // RULE_05
      sample_strobe_q <= conv_edge & ~pd_s;
      decayed_q <= ~pd_s & ~vld_q[LATENCY-1];
    end
  end

endmodule : converter_end

//--- rtl/capture_end.sv
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = adc_pkg::DATA_W,
  parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth
    $error("sample_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  // Honest full and empty from pointers with a wrap bit
  wire empty = (wr_q == rd_q);
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire push = in_valid & ~full;
  wire pop = out_ready & ~empty;
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Pointer and storage update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q[AW-1:0]] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : sample_fifo

module capture_end #(
  parameter int HALF_CYC = adc_pkg::CONV_HALF_CYC,
  parameter int LATENCY = adc_pkg::PIPE_LATENCY
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link to converter
  adc_link_if.capture lk,
  // User controls
  input wire logic run,
  input wire logic pd_req,
  input wire logic fmt_sel,
  input wire adc_pkg::range_e range_sel,
  input wire logic overrun_clr,
  // Sample stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [adc_pkg::DATA_W-1:0] out_data,
  output logic overrun_q
);
  localparam int W = adc_pkg::DATA_W;
  localparam int FREQ_KHZ = adc_pkg::CLK_MHZ * 1000 / (2 * HALF_CYC);
  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
  localparam logic [4:0] SKIP_N = 5'(LATENCY + 2);

  // Conversion clock must stay in its legal band
  if (FREQ_KHZ < adc_pkg::CONV_MIN_MHZ * 1000 ||
      FREQ_KHZ > adc_pkg::CONV_MAX_MHZ * 1000 ||
      HALF_CYC > 255) begin : bad_rate
    $error("capture_end: HALF_CYC gives an illegal conversion rate");
  end

  // Skip counter is five bits wide
  if (LATENCY < 1 || LATENCY > 29) begin : bad_latency
    $error("capture_end: LATENCY must be 1 to 29");
  end

  logic [7:0] div_q;
  logic conv_q, pd_q, fmt_q, rng_o_q, rng_oe_q;
  logic [W-1:0] d1_q, d2_q;
  logic [4:0] skip_q;
  wire half_done = (div_q == HALF_M1);
  wire rise = run & half_done & ~conv_q; // RULE_11
  wire keep = rise & (skip_q == 5'h00);
  wire fifo_ready;

  // A high phase already begun runs to its end when run drops
  wire div_on = run | conv_q;

  // Even divider gives 50% duty and never pauses while run is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      conv_q <= 1'b0;
    end else if (!div_on) begin
      div_q <= 8'h00;
      conv_q <= 1'b0;
    end else if (half_done) begin
      div_q <= 8'h00; // RULE_04
      conv_q <= ~conv_q; // RULE_02 RULE_03
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Static control pins and data synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b1;
      fmt_q <= 1'b0;
      rng_o_q <= 1'b1;
      rng_oe_q <= 1'b1;
      d1_q <= '0;
      d2_q <= '0;
    end else begin
      pd_q <= pd_req;
      fmt_q <= fmt_sel;
      rng_o_q <= (range_sel == adc_pkg::RANGE_2V0);
      rng_oe_q <= (range_sel != adc_pkg::RANGE_1V0);
      d1_q <= lk.data;
      d2_q <= d1_q;
    end
  end

  // Words are discarded in power-down and while the pipeline refills
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_q <= SKIP_N;
      overrun_q <= 1'b0;
    end else begin
      if (pd_q || !run) begin
        skip_q <= SKIP_N; // RULE_06 RULE_07
      end else if (rise && skip_q != 5'h00) begin
        skip_q <= skip_q - 5'h01;
      end
      if (keep && !fifo_ready) begin
        overrun_q <= 1'b1;
      end else if (overrun_clr) begin
        overrun_q <= 1'b0;
      end
    end
  end

  assign lk.conv_clk = conv_q;
  assign lk.power_down_request = pd_q;
  assign lk.output_format_select = fmt_q;
  assign lk.range_o = rng_o_q;
  assign lk.range_oe = rng_oe_q;

  sample_fifo #(.WIDTH(W), .DEPTH(adc_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(keep),
    .in_ready(fifo_ready),
    .in_data(d2_q),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule : capture_end

//--- tb/adc_link_monitor.sv
`timescale 1ns/100ps
module adc_link_monitor (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic conv_clk,
  input wire logic power_down_request,
  input wire logic output_format_select,
  input wire logic range_o,
  input wire logic range_oe,
  input wire logic range_hi,
  input wire logic range_lo,
  input wire logic [adc_pkg::DATA_W-1:0] data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // Edge age
  // ************************************************************
  logic [3:0] age_q;

  // Clocks since the last seen rise of the conversion clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= 4'hF;
    end else if ($rose(conv_clk)) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end

  // ************************************************************
  // Link checks
  // ************************************************************
  chk_pd_clears_word: assert property (
    $rose(power_down_request) |-> ##[0:4] data == 10'h000)
    else $error("word not cleared after power-down");
  chk_pd_word_idle: assert property (
    power_down_request[*6] |-> data == 10'h000)
    else $error("word moved during power-down");
  chk_word_edge_lag: assert property (
    !power_down_request[*6] ##0 $changed(data) |-> age_q inside {[2:3]})
    else $error("word changed away from its clock edge");
  chk_word_holds: assert property (
    !power_down_request[*6] ##0 $rose(conv_clk) |-> ##1 $stable(data)[*2])
    else $error("word not held after clock rise");
  chk_clk_high_phase: assert property (
    $rose(conv_clk) |-> conv_clk[*4] ##1 !conv_clk)
    else $error("conversion clock high phase wrong");
  chk_clk_low_phase: assert property (
    $fell(conv_clk) |-> !conv_clk[*4])
    else $error("conversion clock low phase short");
  chk_pd_at_start: assert property (
    $rose(rst_n) |-> power_down_request)
    else $error("power-down not held out of reset");
  chk_range_single: assert property (
    !(range_hi && range_lo))
    else $error("range pin high and low at once");

  cover property ($rose(power_down_request));
  cover property ($rose(conv_clk) && output_format_select);
  cover property (!range_oe && $rose(conv_clk));
endmodule : adc_link_monitor

//--- tb/pipelined_adc_digital_interface_test.sv
`timescale 1ns/100ps
module pipelined_adc_digital_interface_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [15:0] ain_mv = 16'sh0000;
  logic run = 1'b0;
  logic pd_req = 1'b1;
  logic fmt_sel = 1'b0;
  adc_pkg::range_e range_sel = adc_pkg::RANGE_2V0;
  logic overrun_clr = 1'b0;
  logic out_ready = 1'b1;
  logic out_valid;
  logic [9:0] out_data;
  logic overrun_q;
  logic pwr_dn;
  logic strobe;
  logic decayed;
  int n_mismatch = 0;
  int cmp_count = 0;
  int mv_t[10] = '{0, -1, 700, 700, 1200, -1100, 300, -300, -250, 400};
  adc_pkg::range_e rg_t[10] = '{adc_pkg::RANGE_2V0, adc_pkg::RANGE_2V0,
    adc_pkg::RANGE_2V0, adc_pkg::RANGE_2V0, adc_pkg::RANGE_2V0,
    adc_pkg::RANGE_2V0, adc_pkg::RANGE_1V5, adc_pkg::RANGE_1V5,
    adc_pkg::RANGE_1V0, adc_pkg::RANGE_1V0};
  logic [9:0] fm_v = 10'h168;

  // Clock
  always #2 clk = ~clk;

  // ************************************************************
  // Both ends and the link
  // ************************************************************
  adc_link_if i_adc_link_if ();
  converter_end i_converter_end (.clk(clk), .rst_n(rst_n),
    .lk(i_adc_link_if), .ain_mv(ain_mv), .powered_down_q(pwr_dn),
    .sample_strobe_q(strobe), .decayed_q(decayed));
  capture_end i_capture_end (.clk(clk), .rst_n(rst_n),
    .lk(i_adc_link_if), .run(run), .pd_req(pd_req), .fmt_sel(fmt_sel),
    .range_sel(range_sel), .overrun_clr(overrun_clr),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .overrun_q(overrun_q));
  adc_link_monitor i_adc_link_monitor (.clk(clk), .rst_n(rst_n),
    .conv_clk(i_adc_link_if.conv_clk),
    .power_down_request(i_adc_link_if.power_down_request),
    .output_format_select(i_adc_link_if.output_format_select),
    .range_o(i_adc_link_if.range_o), .range_oe(i_adc_link_if.range_oe),
    .range_hi(i_adc_link_if.range_hi), .range_lo(i_adc_link_if.range_lo),
    .data(i_adc_link_if.data));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check_word(string name, logic [9:0] exp, logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_bit(string name, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %b, seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // Next drained word, bounded wait
  task automatic get_word(output logic [9:0] w);
    int i;
    for (i = 0; i < 300 && out_valid !== 1'b1; i++) @(negedge clk);
    check_bit("out_valid", 1'b1, out_valid);
    if (out_valid !== 1'b1) summarize();
    w = out_data;
    @(negedge clk);
  endtask : get_word

  // Counts strobe pulses over a number of falling edges
  task automatic count_strobes(input int cycles, output int n);
    int k;
    n = 0;
    for (k = 0; k < cycles; k++) begin
      @(negedge clk);
      if (strobe === 1'b1) n++;
    end
  endtask : count_strobes

  function automatic int span_of(adc_pkg::range_e r);
    case (r)
      adc_pkg::RANGE_1V5: span_of = adc_pkg::SPAN_1V5_MV;
      adc_pkg::RANGE_1V0: span_of = adc_pkg::SPAN_1V0_MV;
      default: span_of = adc_pkg::SPAN_2V0_MV;
    endcase
  endfunction : span_of

  // Ideal code: floor of the scaled input, clamped, MSB flipped in tc
  function automatic logic [9:0] exp_code(int mv, int span, logic fmt);
    int q;
    q = (mv * 1024) / span;
    if (mv * 1024 < 0 && q * span != mv * 1024) q--;
    q = q + 512;
    if (q < 0) q = 0;
    if (q > 1023) q = 1023;
    exp_code = 10'(q) ^ {fmt, 9'h000};
  endfunction : exp_code

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_codes();
    int i;
    int n;
    logic [9:0] w;
    for (i = 0; i < 10; i++) begin
      ain_mv = 16'(mv_t[i]);
      range_sel = rg_t[i];
      fmt_sel = fm_v[i];
      repeat (100) @(negedge clk);
      get_word(w);
      check_word("word", exp_code(mv_t[i], span_of(rg_t[i]), fm_v[i]),
        w);
      check_bit("format pin", fm_v[i],
        i_adc_link_if.output_format_select);
      check_word("range pins", {8'h00, rg_t[i] == adc_pkg::RANGE_2V0,
        rg_t[i] == adc_pkg::RANGE_1V5}, {8'h00, i_adc_link_if.range_hi,
        i_adc_link_if.range_lo});
    end
    count_strobes(96, n);
    check_word("strobes", 10'h00C, 10'(n));
  endtask : test_codes

  task automatic test_power_down();
    int i;
    int n;
    logic [9:0] w;
    run = 1'b0;
    repeat (20) @(negedge clk);
    check_bit("idle clock", 1'b0, i_adc_link_if.conv_clk);
    check_bit("decayed", 1'b1, decayed);
    pd_req = 1'b1;
    ain_mv = 16'sh0064;
    repeat (10) @(negedge clk);
    check_bit("powered down", 1'b1, pwr_dn);
    check_word("pd word", adc_pkg::PD_PATTERN,
      i_adc_link_if.data);
    run = 1'b1;
    count_strobes(200, n);
    check_word("pd strobes", 10'h000, 10'(n));
    check_bit("pd valid", 1'b0, out_valid);
    pd_req = 1'b0;
    for (i = 0; i < 300 && out_valid !== 1'b1; i++) @(negedge clk);
    check_bit("stale skipped", 1'b1, i >= 56);
    get_word(w);
    check_word("first word", exp_code(100, span_of(range_sel), fmt_sel),
      w);
  endtask : test_power_down

  task automatic test_overrun();
    int i;
    out_ready = 1'b0;
    repeat (128) @(negedge clk);
    check_bit("overrun", 1'b1, overrun_q);
    run = 1'b0;
    repeat (20) @(negedge clk);
    out_ready = 1'b1;
    for (i = 0; i < 20 && out_valid === 1'b1; i++) @(negedge clk);
    check_word("drained", 10'(adc_pkg::FIFO_DEPTH), 10'(i));
    overrun_clr = 1'b1;
    @(negedge clk);
    overrun_clr = 1'b0;
    @(negedge clk);
    check_bit("overrun clear", 1'b0, overrun_q);
    run = 1'b1;
  endtask : test_overrun

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    run = 1'b1;
    pd_req = 1'b0;
    test_codes();
    $display("codes test done");
    test_power_down();
    $display("power-down test done");
    test_overrun();
    $display("overrun test done");
    summarize();
  end
endmodule : pipelined_adc_digital_interface_test
